// >>> rtl/dlpsc_top.sv
// Functional notes
// [RULE_01] CS, RAS, CAS, CKE low with WE high enters self refresh.
// [RULE_02] Controller turns ODT off before self refresh entry.
// [RULE_03] Controller holds CKE low in self refresh; other inputs ignored.
// [RULE_04] DLL and internal clock off in self refresh, DLL back on exit.
// [RULE_05] One internal refresh within tCKE; residency at least tCKE.
// [RULE_06] Controller may halt clock one cycle after entry; restart before exit.
// [RULE_07] Controller waits tXSNR after exit, issuing only NOP or Deselect.
// [RULE_08] Controller keeps CKE high and ODT off during tXSRD.
// [RULE_09] Before self refresh re-entry, wait tXSNR and give one refresh.
// [RULE_10] CKE low with NOP or Deselect enters power-down, not mid burst; code still enters mid burst and sets cke_drop_event.
// [RULE_11] Controller enters power-down with DLL locked or resets DLL later.
// [RULE_12] No open row gives precharge power-down, else active power-down.
// [RULE_13] Mode bit A12 picks fast or slow active power-down exit.
// [RULE_14] Power-down gates buffers; precharge power-down also stops the DLL.
// [RULE_15] Controller limits power-down to nine times tREFI.
// [RULE_16] CKE high with NOP or Deselect exits power-down.
// [RULE_17] Asynchronous CKE drop loses data; controller must re-initialize.
// [RULE_18] Clock frequency changes only in precharge power-down after 2 clocks.
// [RULE_19] During frequency change ODT, CKE stay low; DLL reset after exit.
// [RULE_20] CS low with RAS, CAS, WE high is a no-operation.
// [RULE_21] CS high is Deselect and acts as a no-operation.
// [RULE_22] Controller issues refresh at most nine tREFI apart.
// [RULE_23] Controller converts ns timing to rounded-up cycle counts.
`timescale 1ns/10ps
`include "dlpsc_consts.svh"

module dlpsc_top (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  // Sampled pins
  input  wire logic                   cke,
  input  wire dlpsc_pkg::dlpsc_cmd_s  cmd,
  // Array and mode status
  input  wire logic                   any_row_open,
  input  wire logic                   burst_busy,
  input  wire logic [`DLPSC_MR_W-1:0] mode_reg,
  // Power controls
  output dlpsc_pkg::dlpsc_pwr_s       pwr,
  // Status
  output dlpsc_pkg::dlpsc_state_e     state,
  output logic                        sref_min_met,
  output logic                        freq_change_ok,
  output logic                        cke_drop_event
);

  localparam logic [`DLPSC_CNT_W-1:0] TCKE_CYC = `DLPSC_CNT_W'(`DLPSC_TCKE_CYC);
  localparam logic [`DLPSC_CNT_W-1:0] TRFC_CYC = `DLPSC_CNT_W'(`DLPSC_TRFC_CYC);
  localparam logic [`DLPSC_CNT_W-1:0] CNT_ONE  = `DLPSC_CNT_W'(1);
  localparam logic [`DLPSC_CNT_W-1:0] CNT_ZERO = '0;

  dlpsc_pkg::dlpsc_cmd_e     kind;
  dlpsc_pkg::dlpsc_state_e   state_q, state_d;
  logic [`DLPSC_CNT_W-1:0]   res_q, res_d;
  logic [`DLPSC_CNT_W-1:0]   busy_q, busy_d;
  logic                      refd_q, refd_d;
  logic                      slow_q, slow_d;
  logic                      drop_q, drop_d;
  dlpsc_pkg::dlpsc_pwr_s     pwr_q, pwr_d;
  logic                      idle_cmd;

  dlpsc_decode u_decode (
    .cmd  (cmd),
    .cke  (cke),
    .kind (kind)
  );

  // NOP and Deselect behave the same everywhere
  assign idle_cmd = (kind == dlpsc_pkg::DLPSC_CMD_NOP) ||
                    (kind == dlpsc_pkg::DLPSC_CMD_DESEL); // see [RULE_21]

  // Saturating increment shared by the residency counter
  function automatic logic [`DLPSC_CNT_W-1:0] sat_inc(input logic [`DLPSC_CNT_W-1:0] v);
    sat_inc = (v == {`DLPSC_CNT_W{1'b1}}) ? v : v + CNT_ONE;
  endfunction

  always_comb begin
    state_d = state_q;
    res_d   = res_q;
    busy_d  = (busy_q != CNT_ZERO) ? busy_q - CNT_ONE : busy_q;
    refd_d  = refd_q;
    slow_d  = slow_q;
    drop_d  = 1'b0;
    unique case (state_q)
      dlpsc_pkg::DLPSC_IDLE: begin
        if (kind == dlpsc_pkg::DLPSC_CMD_SREF) begin
          state_d = dlpsc_pkg::DLPSC_SREF; // see [RULE_01]
          res_d   = CNT_ZERO;
          refd_d  = 1'b0;
        end else if (!cke && idle_cmd) begin // see [RULE_10]
          // Open rows decide the power-down flavour
          state_d = any_row_open ? dlpsc_pkg::DLPSC_APD : dlpsc_pkg::DLPSC_PPD; // see [RULE_12]
          slow_d  = mode_reg[`DLPSC_MR_SLOW_EXIT]; // see [RULE_13]
          res_d   = CNT_ZERO;
          // A CKE drop mid burst is flagged; contents are no longer trusted
          drop_d  = burst_busy; // see [RULE_17]
        end else if (!cke) begin
          drop_d  = 1'b1; // see [RULE_17]
        end
      end
      dlpsc_pkg::DLPSC_PPD,
      dlpsc_pkg::DLPSC_APD: begin
        res_d = sat_inc(res_q);
        if (cke && idle_cmd) begin
          state_d = dlpsc_pkg::DLPSC_IDLE; // see [RULE_16]
        end
      end
      dlpsc_pkg::DLPSC_SREF: begin
        res_d = sat_inc(res_q);
        // One timer refresh right away, well inside the residency minimum
        if (!refd_q) begin
          refd_d = 1'b1; // see [RULE_05]
          busy_d = TRFC_CYC;
        end
        // Only CKE is looked at here; exit honours the residency floor
        if (cke && (res_q >= TCKE_CYC)) begin
          state_d = dlpsc_pkg::DLPSC_SRX; // see [RULE_03]
        end
      end
      dlpsc_pkg::DLPSC_SRX: begin
        // Internal refresh in flight finishes before idle
        if (busy_q == CNT_ZERO) begin
          state_d = dlpsc_pkg::DLPSC_IDLE;
        end
      end
      default: begin
        state_d = dlpsc_pkg::DLPSC_IDLE;
      end
    endcase
  end

  always_comb begin
    pwr_d                = '0;
    pwr_d.slow_exit      = slow_d;
    pwr_d.refresh_pulse  = (state_q == dlpsc_pkg::DLPSC_SREF) && !refd_q; // see [RULE_05]
    unique case (state_d)
      dlpsc_pkg::DLPSC_SREF: begin
        pwr_d.dll_enable     = 1'b0; // see [RULE_04]
        pwr_d.int_clk_enable = 1'b0;
        pwr_d.buffers_enable = 1'b0;
      end
      dlpsc_pkg::DLPSC_PPD: begin
        pwr_d.dll_enable     = 1'b0; // see [RULE_14]
        pwr_d.int_clk_enable = 1'b1;
        pwr_d.buffers_enable = 1'b0;
      end
      dlpsc_pkg::DLPSC_APD: begin
        pwr_d.dll_enable     = 1'b1;
        pwr_d.int_clk_enable = 1'b1;
        pwr_d.buffers_enable = 1'b0; // see [RULE_14]
      end
      default: begin
        pwr_d.dll_enable     = 1'b1; // see [RULE_04]
        pwr_d.int_clk_enable = 1'b1;
        pwr_d.buffers_enable = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= dlpsc_pkg::DLPSC_IDLE;
      res_q   <= '0;
      busy_q  <= '0;
      refd_q  <= 1'b0;
      slow_q  <= 1'b0;
      drop_q  <= 1'b0;
      pwr_q   <= '{dll_enable: 1'b1, int_clk_enable: 1'b1, buffers_enable: 1'b1,
                   refresh_pulse: 1'b0, slow_exit: 1'b0};
    end else if (clk_en) begin
      state_q <= state_d;
      res_q   <= res_d;
      busy_q  <= busy_d;
      refd_q  <= refd_d;
      slow_q  <= slow_d;
      drop_q  <= drop_d;
      pwr_q   <= pwr_d;
    end
  end

  assign pwr            = pwr_q;
  assign state          = state_q;
  assign cke_drop_event = drop_q;
  assign sref_min_met   = (state_q == dlpsc_pkg::DLPSC_SREF) && (res_q >= TCKE_CYC);
  // Frequency change window opens only in precharge power-down
  assign freq_change_ok = (state_q == dlpsc_pkg::DLPSC_PPD) &&
                          (res_q >= `DLPSC_FREQ_CHG_CYC); // see [RULE_18]

  property p_sref_entry;
    @(posedge clk) disable iff (reset)
      (clk_en && state_q == dlpsc_pkg::DLPSC_IDLE && kind == dlpsc_pkg::DLPSC_CMD_SREF)
      |=> (state_q == dlpsc_pkg::DLPSC_SREF);
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("Self refresh not entered"); // see [RULE_01]

  property p_sref_dll_off;
    @(posedge clk) disable iff (reset)
      (state_q == dlpsc_pkg::DLPSC_SREF) |-> (!pwr.dll_enable && !pwr.int_clk_enable);
  endproperty
  a_sref_dll_off: assert property (p_sref_dll_off) else $error("DLL on in self refresh"); // see [RULE_04]

  property p_sref_refresh;
    @(posedge clk) disable iff (reset)
      (clk_en && $rose(state_q == dlpsc_pkg::DLPSC_SREF)) |=> pwr.refresh_pulse;
  endproperty
  a_sref_refresh: assert property (p_sref_refresh) else $error("No refresh in self refresh"); // see [RULE_05]

  property p_sref_floor;
    @(posedge clk) disable iff (reset)
      (state_q == dlpsc_pkg::DLPSC_SREF && state_d == dlpsc_pkg::DLPSC_SRX)
      |-> (res_q >= TCKE_CYC);
  endproperty
  a_sref_floor: assert property (p_sref_floor) else $error("Self refresh left early"); // see [RULE_05]

  property p_pd_entry;
    @(posedge clk) disable iff (reset)
      (clk_en && state_q == dlpsc_pkg::DLPSC_IDLE && !cke && idle_cmd)
      |=> (state_q == (($past(any_row_open)) ? dlpsc_pkg::DLPSC_APD : dlpsc_pkg::DLPSC_PPD));
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("Wrong power-down flavour"); // see [RULE_12]

  property p_slow_exit;
    @(posedge clk) disable iff (reset)
      (clk_en && state_q == dlpsc_pkg::DLPSC_IDLE && !cke && idle_cmd)
      |=> ##1 (pwr.slow_exit == $past(mode_reg[`DLPSC_MR_SLOW_EXIT], 2));
  endproperty
  a_slow_exit: assert property (p_slow_exit) else $error("Exit mode not captured"); // see [RULE_13]

  property p_pd_buffers;
    @(posedge clk) disable iff (reset)
      (state_q == dlpsc_pkg::DLPSC_PPD) |-> (!pwr.buffers_enable && !pwr.dll_enable);
  endproperty
  a_pd_buffers: assert property (p_pd_buffers) else $error("Buffers on in power-down"); // see [RULE_14]

  property p_pd_exit;
    @(posedge clk) disable iff (reset)
      (clk_en && (state_q == dlpsc_pkg::DLPSC_PPD || state_q == dlpsc_pkg::DLPSC_APD)
       && cke && idle_cmd) |=> (state_q == dlpsc_pkg::DLPSC_IDLE);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("Power-down not exited"); // see [RULE_16]

  property p_nop_hold;
    @(posedge clk) disable iff (reset)
      (clk_en && state_q == dlpsc_pkg::DLPSC_IDLE && cke && idle_cmd)
      |=> (state_q == dlpsc_pkg::DLPSC_IDLE);
  endproperty
  a_nop_hold: assert property (p_nop_hold) else $error("NOP changed state"); // see [RULE_20]

  property p_desel;
    @(posedge clk) disable iff (reset)
      cmd.cs_n |-> (kind == dlpsc_pkg::DLPSC_CMD_DESEL);
  endproperty
  a_desel: assert property (p_desel) else $error("Deselect misdecoded"); // see [RULE_21]

endmodule // dlpsc_top

// >>> rtl/dlpsc_consts.svh
`ifndef DLPSC_CONSTS_SVH
`define DLPSC_CONSTS_SVH

// Clock period in ns
`define DLPSC_CLK_NS          32'd50
// Least self refresh residency and time to first internal refresh, ns
`define DLPSC_TCKE_NS         32'd150
// Least cycles of self refresh residency, rounded up
`define DLPSC_TCKE_CYC        (((`DLPSC_TCKE_NS) + (`DLPSC_CLK_NS) - 32'd1) / (`DLPSC_CLK_NS))
// Internal refresh busy time after a timer refresh, ns
`define DLPSC_TRFC_NS         32'd128
`define DLPSC_TRFC_CYC        (((`DLPSC_TRFC_NS) + (`DLPSC_CLK_NS) - 32'd1) / (`DLPSC_CLK_NS))
// Counter width for residency and refresh timing
`define DLPSC_CNT_W           8
// Clocks after self refresh entry before the link clock may stop
`define DLPSC_CLK_HALT_CYC    8'h01
// Clocks in precharge power-down before a frequency change is allowed
`define DLPSC_FREQ_CHG_CYC    8'h02
// Mode register bit selecting slow active power-down exit
`define DLPSC_MR_SLOW_EXIT    12
`define DLPSC_MR_W            13

`endif

// >>> rtl/dlpsc_pkg.sv
package dlpsc_pkg;

  typedef enum logic [2:0] {
    DLPSC_IDLE  = 3'b000,
    DLPSC_PPD   = 3'b001,
    DLPSC_APD   = 3'b011,
    DLPSC_SREF  = 3'b010,
    DLPSC_SRX   = 3'b110
  } dlpsc_state_e;

  typedef enum logic [2:0] {
    DLPSC_CMD_NOP   = 3'h0,
    DLPSC_CMD_DESEL = 3'h1,
    DLPSC_CMD_REF   = 3'h2,
    DLPSC_CMD_SREF  = 3'h3,
    DLPSC_CMD_OTHER = 3'h4
  } dlpsc_cmd_e;

  // Command pins sampled on the rising clock
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dlpsc_cmd_s;

  // Power controls driven toward the array, DLL and buffers
  typedef struct packed {
    logic dll_enable;
    logic int_clk_enable;
    logic buffers_enable;
    logic refresh_pulse;
    logic slow_exit;
  } dlpsc_pwr_s;

endpackage

// >>> rtl/dlpsc_decode.sv
`timescale 1ns/10ps
`include "dlpsc_consts.svh"

module dlpsc_decode (
  // Sampled pins
  input  wire dlpsc_pkg::dlpsc_cmd_s cmd,
  input  wire logic                  cke,
  // Decoded command
  output dlpsc_pkg::dlpsc_cmd_e      kind
);

  always_comb begin
    if (cmd.cs_n) begin
      kind = dlpsc_pkg::DLPSC_CMD_DESEL; // see [RULE_21]
    end else if (cmd.ras_n && cmd.cas_n && cmd.we_n) begin
      kind = dlpsc_pkg::DLPSC_CMD_NOP; // see [RULE_20]
    end else if (!cmd.ras_n && !cmd.cas_n && cmd.we_n) begin
      kind = cke ? dlpsc_pkg::DLPSC_CMD_REF : dlpsc_pkg::DLPSC_CMD_SREF; // see [RULE_01]
    end else begin
      kind = dlpsc_pkg::DLPSC_CMD_OTHER;
    end
  end

endmodule // dlpsc_decode

// >>> sim/dlpsc_ctrl_model.sv
`timescale 1ns/10ps

module dlpsc_ctrl_model (
  // Clock
  input  wire logic             clk,
  // Pins toward the device
  output logic                  clk_en,
  output logic                  cke,
  output dlpsc_pkg::dlpsc_cmd_s cmd
);
  // No termination pin here, so termination is always off
  initial begin
    clk_en = 1'b1;
    cke    = 1'b1;
    cmd    = 4'h7;
  end

  // Caller sits on a falling edge; pins stand until the next call
  task automatic send(input logic cke_v, input logic [3:0] pins);
    cke = cke_v;
    cmd = pins;
  endtask

  // Stop the clock, only ever one clock or more after self refresh entry
  task automatic halt(input int n);
    clk_en = 1'b0;
    repeat (n) @(negedge clk);
    clk_en = 1'b1;
  endtask
endmodule // dlpsc_ctrl_model

// >>> sim/dlpsc_top_test.sv
`timescale 1ns/10ps
`include "dlpsc_consts.svh"

module dlpsc_top_test;
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [3:0] SRE = 4'h1;
  localparam logic [3:0] DES = 4'h8;
  localparam logic [3:0] ACT = 4'h3;
  logic                    clk, reset, clk_en, cke, any_row_open, burst_busy;
  logic                    sref_min_met, freq_change_ok, cke_drop_event;
  logic [`DLPSC_MR_W-1:0]  mode_reg;
  dlpsc_pkg::dlpsc_cmd_s   cmd;
  dlpsc_pkg::dlpsc_pwr_s   pwr;
  dlpsc_pkg::dlpsc_state_e state;
  int                      failures, compares, cycles, pulses;

  dlpsc_ctrl_model ctl (.clk(clk), .clk_en(clk_en), .cke(cke), .cmd(cmd));
  dlpsc_top dut (.clk(clk), .reset(reset), .clk_en(clk_en), .cke(cke), .cmd(cmd),
    .any_row_open(any_row_open), .burst_busy(burst_busy), .mode_reg(mode_reg),
    .pwr(pwr), .state(state), .sref_min_met(sref_min_met),
    .freq_change_ok(freq_change_ok), .cke_drop_event(cke_drop_event));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang is cut short well past the fewer than a hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end

  always @(negedge clk) if (pwr.refresh_pulse === 1'b1) pulses++;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_state(input dlpsc_pkg::dlpsc_state_e exp);
    chk({5'h0, state}, {5'h0, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rst;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk_state(dlpsc_pkg::DLPSC_IDLE);
    chk({3'h0, pwr}, 8'h1c);
    chk({7'h0, cke_drop_event}, 8'h00);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (state !== dlpsc_pkg::DLPSC_IDLE && n < 6) begin
      step(1);
      n++;
    end
  endtask

  // Residency is short, so the bound on the wait also bounds the design
  task automatic sr_stay_exit;
    int n;
    n = 0;
    while (sref_min_met !== 1'b1 && n < `DLPSC_TCKE_CYC + 2) begin
      step(1);
      n++;
    end
    chk({7'h0, sref_min_met}, 8'h01);
    chk({7'h0, pulses != 0}, 8'h01);
    ctl.send(1'b1, NOP);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_SRX);
    wait_idle();
    chk_state(dlpsc_pkg::DLPSC_IDLE);
    chk({3'h0, pwr}, 8'h1c);
  endtask

  task automatic t_idle;
    ctl.send(1'b1, NOP);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_IDLE);
    chk({7'h0, cke_drop_event}, 8'h00);
  endtask

  task automatic t_sref;
    pulses = 0;
    ctl.send(1'b0, SRE);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_SREF);
    chk({5'h0, pwr.dll_enable, pwr.int_clk_enable, pwr.buffers_enable}, 8'h00);
    // CKE stays low; the stray command must be ignored
    ctl.send(1'b0, ACT);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_SREF);
    ctl.send(1'b0, NOP);
    ctl.halt(4);
    chk_state(dlpsc_pkg::DLPSC_SREF);
    sr_stay_exit();
    // Extra refresh and its busy time before going back in
    ctl.send(1'b1, SRE);
    step(1);
    ctl.send(1'b1, NOP);
    step(`DLPSC_TRFC_CYC);
    pulses = 0;
    ctl.send(1'b0, SRE);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_SREF);
    ctl.send(1'b0, DES);
    sr_stay_exit();
  endtask

  task automatic t_ppd;
    any_row_open = 1'b0;
    chk({7'h0, pwr.dll_enable}, 8'h01);
    ctl.send(1'b0, NOP);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_PPD);
    chk({6'h0, pwr.dll_enable, pwr.buffers_enable}, 8'h00);
    chk({7'h0, freq_change_ok}, 8'h00);
    ctl.send(1'b0, ACT);
    step(2);
    chk_state(dlpsc_pkg::DLPSC_PPD);
    chk({7'h0, freq_change_ok}, 8'h01);
    ctl.send(1'b1, NOP);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_IDLE);
  endtask

  task automatic t_apd(input logic slow);
    mode_reg = {slow, 12'h000};
    any_row_open = 1'b1;
    ctl.send(1'b0, DES);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_APD);
    chk({7'h0, pwr.slow_exit}, {7'h0, slow});
    chk({6'h0, pwr.dll_enable, pwr.buffers_enable}, 8'h02);
    step(2);
    chk({7'h0, freq_change_ok}, 8'h00);
    ctl.send(1'b1, DES);
    step(1);
    chk_state(dlpsc_pkg::DLPSC_IDLE);
    any_row_open = 1'b0;
  endtask

  task automatic t_drop(input logic busy, input logic [3:0] pins);
    rst();
    burst_busy = busy;
    ctl.send(1'b0, pins);
    step(1);
    chk({7'h0, cke_drop_event}, 8'h01);
    burst_busy = 1'b0;
    ctl.send(1'b1, NOP);
    step(1);
    chk({7'h0, cke_drop_event}, 8'h00);
    rst();
  endtask

  initial begin
    reset = 1'b1;
    any_row_open = 1'b0;
    burst_busy = 1'b0;
    mode_reg = '0;
    failures = 0;
    compares = 0;
    cycles = 0;
    pulses = 0;
    step(6);
    reset = 1'b0;
    chk_state(dlpsc_pkg::DLPSC_IDLE);
    chk({3'h0, pwr}, 8'h1c);
    t_idle();
    t_sref();
    t_ppd();
    t_apd(1'b0);
    t_apd(1'b1);
    t_drop(1'b0, ACT);
    t_drop(1'b1, NOP);
    t_idle();
    finish_test();
  end
endmodule // dlpsc_top_test
